// ### src/eip2_regs.vh
// Register address, field positions and reset value for the extended priority register two.
`ifndef EIP2_REGS_VH
`define EIP2_REGS_VH
`define EIP2_ADDR 8'hf7
`define EIP2_RESET 8'h00
`define EIP2_RADIO_SERIAL_BIT 3
`define EIP2_RTC_ALARM_BIT 2
`define EIP2_PORT_MATCH_BIT 1
`define EIP2_SUPPLY_WARNING_BIT 0
`define EIP2_USED_MASK 8'h0f
`define EIP2_NUM_SRC 4
`endif

// ### src/eip2_arb.v
// Two-level priority arbiter for the four sources served by the extended priority register.
`timescale 1ns/1ps
`default_nettype none
module eip2_arb #(
  parameter N = 4
) (
  input wire [N-1:0] req_i,
  input wire [N-1:0] prio_i,
  input wire in_high_i,
  input wire in_low_i,
  output reg grant_valid_o,
  output reg [N-1:0] grant_o,
  output reg grant_high_o
);
  integer k;
  reg [N-1:0] hi_req;
  reg [N-1:0] lo_req;
  always @* begin
    hi_req = req_i & prio_i;
    lo_req = req_i & ~prio_i;
    grant_o = {N{1'b0}};
    grant_valid_o = 1'b0;
    grant_high_o = 1'b0;
    // Lower index wins within a level; a high request beats any low one.
    if (hi_req != {N{1'b0}} && !in_high_i) begin
      for (k = N - 1; k >= 0; k = k - 1) begin
        if (hi_req[k]) begin
          grant_o = {N{1'b0}};
          grant_o[k] = 1'b1;
        end
      end
      grant_valid_o = 1'b1;
      grant_high_o = 1'b1;
    end else if (lo_req != {N{1'b0}} && !in_high_i && !in_low_i) begin
      for (k = N - 1; k >= 0; k = k - 1) begin
        if (lo_req[k]) begin
          grant_o = {N{1'b0}};
          grant_o[k] = 1'b1;
        end
      end
      grant_valid_o = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### src/eip2_top.v
// Extended interrupt priority register two with its two-level arbitration.
// Overview of operation
// - Bits 7:4 read as zero and writes to them are ignored.
// - Bit 3 sets the radio serial port interrupt to high (1) or low (0) priority.
// - Bit 2 sets the real-time clock alarm interrupt to high (1) or low (0) priority.
// - Bit 1 sets the port match interrupt to high (1) or low (0) priority.
// - Bit 0 sets the supply warning interrupt to high (1) or low (0) priority.
// - The register is read and written at address 0xf7 on every register page.
`timescale 1ns/1ps
`default_nettype none
`include "eip2_regs.vh"
module eip2_top (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire [7:0] sfr_addr_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  input wire [7:0] sfr_wdata_i,
  output reg [7:0] sfr_rdata_o,
  output wire sfr_hit_o,
  input wire [3:0] irq_req_i,
  input wire isr_enter_i,
  input wire isr_exit_i,
  output wire radio_serial_irq_priority_o,
  output wire rtc_alarm_irq_priority_o,
  output wire port_match_irq_priority_o,
  output wire supply_warning_irq_priority_o,
  output wire grant_valid_o,
  output wire [3:0] grant_o,
  output wire grant_high_o,
  output wire in_high_o,
  output wire in_low_o
);
  reg [3:0] prio_reg;
  reg in_high_reg;
  reg in_low_reg;
  wire grant_high;
  wire grant_valid;
  // The page select is not decoded, so the register answers on all pages.
  assign sfr_hit_o = (sfr_addr_i == `EIP2_ADDR);
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prio_reg <= 4'h0;
    end else if (sfr_wr_i && sfr_hit_o) begin
      prio_reg <= sfr_wdata_i[3:0];
    end
  end
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sfr_rdata_o <= `EIP2_RESET;
    end else if (sfr_rd_i && sfr_hit_o) begin
      sfr_rdata_o <= {4'h0, prio_reg} & `EIP2_USED_MASK;
    end else begin
      sfr_rdata_o <= 8'h00;
    end
  end
  assign radio_serial_irq_priority_o = prio_reg[`EIP2_RADIO_SERIAL_BIT];
  assign rtc_alarm_irq_priority_o = prio_reg[`EIP2_RTC_ALARM_BIT];
  assign port_match_irq_priority_o = prio_reg[`EIP2_PORT_MATCH_BIT];
  assign supply_warning_irq_priority_o = prio_reg[`EIP2_SUPPLY_WARNING_BIT];
  eip2_arb #(
    .N(`EIP2_NUM_SRC)
  ) u_arb (
    .req_i(irq_req_i),
    .prio_i(prio_reg),
    .in_high_i(in_high_reg),
    .in_low_i(in_low_reg),
    .grant_valid_o(grant_valid),
    .grant_o(grant_o),
    .grant_high_o(grant_high)
  );
  assign grant_valid_o = grant_valid;
  assign grant_high_o = grant_high;
  // Track which service levels are active; a high entry nests over a low one.
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_high_reg <= 1'b0;
      in_low_reg <= 1'b0;
    end else if (isr_enter_i && grant_valid) begin
      if (grant_high) begin
        in_high_reg <= 1'b1;
      end else begin
        in_low_reg <= 1'b1;
      end
    end else if (isr_exit_i) begin
      if (in_high_reg) begin
        in_high_reg <= 1'b0;
      end else begin
        in_low_reg <= 1'b0;
      end
    end
  end
  assign in_high_o = in_high_reg;
  assign in_low_o = in_low_reg;
endmodule
`default_nettype wire

// ### verif/eip2_sva.sv
// Assertions on the register and arbiter ports.
`timescale 1ns/1ps
`default_nettype none
module eip2_sva (
  input wire sys_clk_i, resetn_i, sfr_wr_i, sfr_rd_i, in_high_o, grant_valid_o,
  input wire grant_high_o, radio_serial_irq_priority_o, rtc_alarm_irq_priority_o,
  input wire port_match_irq_priority_o, supply_warning_irq_priority_o,
  input wire [3:0] irq_req_i,
  input wire [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o);
  wire [3:0] prio = {radio_serial_irq_priority_o, rtc_alarm_irq_priority_o,
    port_match_irq_priority_o, supply_warning_irq_priority_o};
  wire hit = sfr_addr_i == 8'hf7;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  AST_UPPER_ZERO:
    assert property (sfr_rdata_o[7:4] == 4'h0) else $error("upper bits set");
  AST_WRITE_READ:
    assert property (sfr_wr_i && hit ##1 sfr_rd_i && hit && !sfr_wr_i
      |=> sfr_rdata_o == {4'h0, $past(sfr_wdata_i[3:0], 2)}) else $error("read back wrong");
  AST_OTHER_ADDR:
    assert property (sfr_rd_i && !hit |=> sfr_rdata_o == 8'h00) else $error("foreign read");
  AST_HIGH_BUSY:
    assert property (in_high_o |-> !grant_valid_o) else $error("grant in high routine");
  AST_PRIO_WRITE:
    assert property (sfr_wr_i && hit |=> prio == $past(sfr_wdata_i[3:0]))
      else $error("priority outputs wrong");
  AST_RDATA_IDLE:
    assert property (!sfr_rd_i |=> sfr_rdata_o == 8'h00) else $error("idle read data");
  AST_HIGH_FIRST:
    assert property ((irq_req_i & prio) != 4'h0 && !in_high_o |-> grant_valid_o && grant_high_o)
      else $error("high request not granted");
endmodule
`default_nettype wire

// ### verif/eip2_core.sv
// Core model: takes an offered grant on command and returns one cycle after entering.
`timescale 1ns/1ps
`default_nettype none
module eip2_core (
  input wire sys_clk_i, resetn_i, accept_i, grant_valid_o,
  output logic enter_o = 1'b0, exit_o = 1'b0);
  always @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i) {enter_o, exit_o} <= 2'b00;
    else {enter_o, exit_o} <= {accept_i & grant_valid_o, enter_o};
endmodule
`default_nettype wire

// ### verif/ext_interrupt_priority_reg2_test.sv
// Bench for the extended priority register two.
`timescale 1ns/1ps
`default_nettype none
module ext_interrupt_priority_reg2_test;
  logic sys_clk_i = 0, resetn_i = 0, sfr_wr_i = 0, sfr_rd_i = 0, acc = 0, sfr_hit_o, in_low_o;
  logic grant_valid_o, grant_high_o, in_high_o, isr_enter_i, isr_exit_i;
  logic radio_serial_irq_priority_o, rtc_alarm_irq_priority_o;
  logic port_match_irq_priority_o, supply_warning_irq_priority_o;
  logic [7:0] sfr_addr_i = 0, sfr_wdata_i = 0, sfr_rdata_o;
  logic [3:0] irq_req_i = 0, grant_o;
  int n_mismatch = 0, n_tests = 0;
  eip2_top u_eip2_top (.*);
  eip2_core u_eip2_core (.sys_clk_i, .resetn_i, .accept_i(acc), .grant_valid_o,
    .enter_o(isr_enter_i), .exit_o(isr_exit_i));
  task chk(input string s, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  task sfr(input logic rd, input logic [7:0] a, d);
    {sfr_rd_i, sfr_wr_i, sfr_addr_i, sfr_wdata_i} = {rd, !rd, a, d};
    @(posedge sys_clk_i) #1;
    if (rd) chk("rdata", d, sfr_rdata_o);
  endtask
  task tally_and_finish;
    $display("mismatches %0d checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial forever #2 sys_clk_i = !sys_clk_i;
  initial begin
    #7 resetn_i = 1;
    for (int i = 0; i < 5; i++) begin
      sfr(1, 8'hf7, 8'h01 << i >> 1);
      if (i < 4) sfr(0, 8'hf7, 8'hf0 | 8'h01 << i);
    end
    chk("prio", 8'h08, {radio_serial_irq_priority_o, rtc_alarm_irq_priority_o,
      port_match_irq_priority_o, supply_warning_irq_priority_o});
    sfr(0, 8'hf6, 8'h00);
    sfr(1, 8'hf6, 8'h00);
    sfr(1, 8'hf7, 8'h08);
    chk("hit", 8'h01, {7'h00, sfr_hit_o});
    {sfr_rd_i, sfr_wr_i, irq_req_i, acc} = 7'h13;
    #1 chk("grant", 8'h38, {grant_valid_o, grant_high_o, grant_o});
    @(posedge sys_clk_i) #1 acc = 0;
    @(posedge sys_clk_i) #1 chk("busy", 8'h02, {in_high_o, grant_valid_o});
    @(posedge sys_clk_i) #1 chk("back", 8'h01, {in_low_o, in_high_o, grant_valid_o});
    {irq_req_i, acc} = 5'h03;
    #1 chk("lgrant", 8'h21, {grant_valid_o, grant_high_o, grant_o});
    @(posedge sys_clk_i) #1 acc = 0;
    @(posedge sys_clk_i) #1 chk("lbusy", 8'h04, {in_low_o, in_high_o, grant_valid_o});
    @(posedge sys_clk_i) #1 chk("lback", 8'h01, {in_low_o, in_high_o, grant_valid_o});
    tally_and_finish;
  end
endmodule
bind eip2_top eip2_sva u_eip2_sva (.*);
`default_nettype wire
